// ---- rtl/pin_ctrl_consts.vh ----
// Constants for the per-pin compare and termination controller.
// Assumes inclusion by the design and test files of that controller only.
`ifndef PIN_CTRL_CONSTS_VH
`define PIN_CTRL_CONSTS_VH

// ********************************************************************
// Pin functions
// ********************************************************************
`define FUNC_DIGITAL    2'h0
`define FUNC_PARAMETRIC 2'h1
`define FUNC_OFF        2'h2
`define FUNC_DISCONNECT 2'h3

// ********************************************************************
// Pattern states, four bits per pin
// ********************************************************************
`define ST_DRIVE0    4'h0
`define ST_DRIVE1    4'h1
`define ST_CMP_LOW   4'h2
`define ST_CMP_HIGH  4'h3
`define ST_MIDBAND   4'h4
`define ST_VALID     4'h5
`define ST_DONT_CARE 4'h6
`define ST_NO_CHANGE 4'h7
`define ST_EDGE      4'h8

// ********************************************************************
// Termination modes
// ********************************************************************
`define TERM_HIGHZ   2'h0
`define TERM_LOAD    2'h1
`define TERM_RESIST  2'h2

// ********************************************************************
// Parametric unit operation codes
// ********************************************************************
`define PMU_NONE     3'h0
`define PMU_FV_NM    3'h1
`define PMU_FV_MV    3'h2
`define PMU_FV_MI    3'h3
`define PMU_FI_NM    3'h4
`define PMU_FI_MV    3'h5
`define PMU_FI_MI    3'h6
`define PMU_MV_NF    3'h7

// ********************************************************************
// Register offsets and reset values
// ********************************************************************
`define REG_CTRL     4'h0
`define REG_STATUS   4'h1
`define REG_MASK     4'h2
`define REG_FAILCNT  4'h3
`define REG_MISMATCH 4'h4
`define REG_PMU      4'h5
`define CTRL_RESET   32'h00000000
`define MASK_RESET   32'h00000000

// Control register fields.
`define CTRL_FUNC_LSB   0
`define CTRL_TERM_LSB   2
`define CTRL_NOCHG_BIT  4
`define CTRL_STATIC_BIT 5

// Status event bits.
`define EV_FAIL_BIT     0
`define EV_MATCH_BIT    1

`endif

// ---- rtl/pin_lane.v ----
// One pin lane: decides driver, load and termination and judges the compare.
// Assumes comparator levels already synchronised by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_consts.vh"

module pin_lane (
  // Pattern and settings
  input  wire [3:0] state,
  input  wire [1:0] func,
  input  wire [1:0] term_mode,
  input  wire       nochg_nondrive,
  input  wire       drive_enable,
  // Comparator levels
  input  wire       above_high,
  input  wire       below_low,
  input  wire       above_commutate,
  // Pin controls
  output reg        drv_en,
  output reg        drv_val,
  output reg        load_en,
  output reg        load_source,
  output reg        term_en,
  output reg        cmp_en,
  // Compare result
  output reg        mismatch
);

  reg nondrive;
  reg digital;

  always @* begin
    digital     = (func == `FUNC_DIGITAL);
    nondrive    = (state == `ST_CMP_LOW) || (state == `ST_CMP_HIGH) ||
                  (state == `ST_MIDBAND) || (state == `ST_VALID) ||
                  (state == `ST_DONT_CARE) || (state == `ST_EDGE) ||
                  ((state == `ST_NO_CHANGE) && nochg_nondrive);
    drv_en      = 1'b0;
    drv_val     = 1'b0;
    load_en     = 1'b0;
    load_source = 1'b0;
    term_en     = 1'b0;
    cmp_en      = digital;
    mismatch    = 1'b0;
    if (digital && drive_enable) begin
      if (!nondrive) begin
        if (state == `ST_DRIVE0 || state == `ST_DRIVE1) begin
          drv_en  = 1'b1;
          drv_val = (state == `ST_DRIVE1);
        end
      end else begin
        case (term_mode)
          `TERM_LOAD: begin
            load_en     = 1'b1;
            load_source = !above_commutate;
          end
          `TERM_RESIST: begin
            term_en = 1'b1;
          end
          default: begin
            drv_en = 1'b0;
          end
        endcase
      end
    end
    if (digital) begin
      case (state)
        `ST_CMP_LOW:  mismatch = !below_low;
        `ST_CMP_HIGH: mismatch = !above_high;
        `ST_VALID:    mismatch = !(above_high || below_low);
        `ST_MIDBAND:  mismatch = above_high || below_low;
        default:      mismatch = 1'b0;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- rtl/sync2.v ----
// Two-flop synchroniser for a vector of levels from outside the clock domain.
// Assumes the levels change slowly against the clock.
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         sys_clk,
  input  wire         resetn,
  input  wire         ce,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/pin_compare_termination_ctrl.v ----
// Per-pin compare, termination and parametric mode control for a pattern channel.
// Assumes one vector per clock with the compare strobe, and comparator pins
// that arrive asynchronously.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_consts.vh"

// Functional notes
// - Termination applies only to digital pins in non-drive states.
// - High-Z mode floats the driver and disables the load.
// - Active-load mode connects the load in non-drive states.
// - Resistive mode terminates the pin to the termination voltage through 50 ohm.
// - Sample comparator results against both thresholds at the compare strobe.
// - Low below low, high above high, valid outside, midband strictly between.
// - Any pin mismatch flags a failure for the whole cycle.
// - The match opcode suppresses the failure for that cycle.
// - The load follows each pin's pattern state cycle by cycle.
// - Load levels apply only with load mode, non-drive state, digital function.
// - Load sources below the commutate level and sinks above it.
// - Parametric unit offers seven force and measure operations.
// - Parametric function switches driver, comparator and load off.
// - After reset every pin stays high impedance until software sets the drive enable bit or selects the parametric function.
module pin_compare_termination_ctrl #(
  parameter PINS = 8
) (
  // Clock, reset, enable
  input  wire              sys_clk,
  input  wire              resetn,
  input  wire              clk_en,
  // Register port
  input  wire [3:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata,
  // Pattern engine
  input  wire [4*PINS-1:0] vec_state,
  input  wire              vec_strobe,
  input  wire              vec_match,
  // Comparator pins
  input  wire [PINS-1:0]   cmp_above_high,
  input  wire [PINS-1:0]   cmp_below_low,
  input  wire [PINS-1:0]   cmp_above_commutate,
  // Pin controls
  output reg  [PINS-1:0]   drv_en,
  output reg  [PINS-1:0]   drv_val,
  output reg  [PINS-1:0]   load_en,
  output reg  [PINS-1:0]   load_source,
  output reg  [PINS-1:0]   term_en,
  output reg  [PINS-1:0]   cmp_en,
  output reg  [PINS-1:0]   pmu_connect,
  output reg  [2:0]        pmu_mode,
  // Results
  output reg               cycle_fail,
  output reg               cycle_valid,
  output reg  [PINS-1:0]   pin_mismatch,
  output reg               irq
);

  // ******************************************************************
  // Settings and interrupt registers
  // ******************************************************************
  reg  [1:0]  func;
  reg  [1:0]  term_mode;
  reg         nochg_nondrive;
  reg         drive_enable;
  reg  [2:0]  pmu_op;
  reg  [1:0]  status;
  reg  [1:0]  mask;
  reg  [15:0] fail_count;

  wire [PINS-1:0] s_high;
  wire [PINS-1:0] s_low;
  wire [PINS-1:0] s_com;

  sync2 #(.W(3*PINS)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (clk_en),
    .d       ({cmp_above_commutate, cmp_below_low, cmp_above_high}),
    .q       ({s_com, s_low, s_high})
  );

  // ******************************************************************
  // Per-pin lanes
  // ******************************************************************
  wire [PINS-1:0] l_drv_en;
  wire [PINS-1:0] l_drv_val;
  wire [PINS-1:0] l_load_en;
  wire [PINS-1:0] l_load_src;
  wire [PINS-1:0] l_term_en;
  wire [PINS-1:0] l_cmp_en;
  wire [PINS-1:0] l_mismatch;

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : lane
      pin_lane u_lane (
        .state           (vec_state[4*g+3:4*g]),
        .func            (func),
        .term_mode       (term_mode),
        .nochg_nondrive  (nochg_nondrive),
        .drive_enable    (drive_enable),
        .above_high      (s_high[g]),
        .below_low       (s_low[g]),
        .above_commutate (s_com[g]),
        .drv_en          (l_drv_en[g]),
        .drv_val         (l_drv_val[g]),
        .load_en         (l_load_en[g]),
        .load_source     (l_load_src[g]),
        .term_en         (l_term_en[g]),
        .cmp_en          (l_cmp_en[g]),
        .mismatch        (l_mismatch[g])
      );
    end
  endgenerate

  // Failure of the cycle before the match opcode is applied.
  wire raw_fail = |l_mismatch;
  wire fail_now = vec_strobe && raw_fail && !vec_match;
  wire match_ev = vec_strobe && raw_fail && vec_match;
  wire [1:0] events = {match_ev, fail_now};

  // ******************************************************************
  // Register writes, pin outputs and compare results
  // ******************************************************************
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      func           <= `FUNC_DIGITAL;
      term_mode      <= `TERM_HIGHZ;
      nochg_nondrive <= 1'b0;
      drive_enable   <= 1'b0;
      pmu_op         <= `PMU_NONE;
      status         <= 2'h0;
      mask           <= 2'h0;
      fail_count     <= 16'h0000;
      drv_en         <= {PINS{1'b0}};
      drv_val        <= {PINS{1'b0}};
      load_en        <= {PINS{1'b0}};
      load_source    <= {PINS{1'b0}};
      term_en        <= {PINS{1'b0}};
      cmp_en         <= {PINS{1'b0}};
      pmu_connect    <= {PINS{1'b0}};
      pmu_mode       <= `PMU_NONE;
      cycle_fail     <= 1'b0;
      cycle_valid    <= 1'b0;
      pin_mismatch   <= {PINS{1'b0}};
      irq            <= 1'b0;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == `REG_CTRL) begin
        func           <= reg_wdata[`CTRL_FUNC_LSB+1:`CTRL_FUNC_LSB];
        term_mode      <= reg_wdata[`CTRL_TERM_LSB+1:`CTRL_TERM_LSB];
        nochg_nondrive <= reg_wdata[`CTRL_NOCHG_BIT];
        drive_enable   <= reg_wdata[`CTRL_STATIC_BIT];
      end
      if (reg_wr && reg_addr == `REG_MASK)
        mask <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `REG_PMU)
        pmu_op <= reg_wdata[2:0];
      // Set wins over a write-one clear in the same cycle.
      if (reg_wr && reg_addr == `REG_STATUS)
        status <= (status & ~reg_wdata[1:0]) | events;
      else
        status <= status | events;
      if (fail_now && fail_count != 16'hFFFF)
        fail_count <= fail_count + 16'h0001;
      // Pins stay floating until software enables drive or selects the parametric function.
      drv_en      <= l_drv_en;
      drv_val     <= l_drv_val;
      load_en     <= l_load_en;
      load_source <= l_load_src;
      term_en     <= l_term_en;
      cmp_en      <= l_cmp_en;
      pmu_connect <= {PINS{func == `FUNC_PARAMETRIC}};
      pmu_mode    <= (func == `FUNC_PARAMETRIC || pmu_op == `PMU_MV_NF) ?
                     pmu_op : `PMU_NONE;
      cycle_valid <= vec_strobe;
      cycle_fail  <= fail_now;
      if (vec_strobe)
        pin_mismatch <= l_mismatch;
      irq <= |(((status & ~((reg_wr && reg_addr == `REG_STATUS) ?
                reg_wdata[1:0] : 2'h0)) | events) & mask);
    end
  end

  // ******************************************************************
  // Register reads
  // ******************************************************************
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `REG_CTRL: begin
        next_rdata[`CTRL_FUNC_LSB+1:`CTRL_FUNC_LSB] = func;
        next_rdata[`CTRL_TERM_LSB+1:`CTRL_TERM_LSB] = term_mode;
        next_rdata[`CTRL_NOCHG_BIT]                 = nochg_nondrive;
        next_rdata[`CTRL_STATIC_BIT]                = drive_enable;
      end
      `REG_STATUS:   next_rdata[1:0]  = status;
      `REG_MASK:     next_rdata[1:0]  = mask;
      `REG_FAILCNT:  next_rdata[15:0] = fail_count;
      `REG_MISMATCH: next_rdata[PINS-1:0] = pin_mismatch;
      `REG_PMU:      next_rdata[2:0]  = pmu_op;
      default:       next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= 32'h00000000;
    else if (clk_en)
      reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
  end

endmodule

`default_nettype wire

// ---- test/dut_pins.sv ----
// Behavioural model of the tested device's pins, seen through the comparators.
// Assumes the bench sets the level class that the device puts out on each pin.
`timescale 1ns/1ps
`default_nettype none

module dut_pins #(
  parameter PINS = 8
) (
  // Driver side of the channel
  input  wire logic [PINS-1:0]   drv_en,
  input  wire logic [PINS-1:0]   drv_val,
  // Output class of the device per pin: 0 low, 1 midband, 2 high
  input  wire logic [2*PINS-1:0] level,
  // Comparator levels
  output var  logic [PINS-1:0]   above_high,
  output var  logic [PINS-1:0]   below_low,
  output var  logic [PINS-1:0]   above_commutate
);
  integer   k;
  logic [1:0] c;

  // A driven pin follows the driver, otherwise the device's own output.
  always @* begin
    for (k = 0; k < PINS; k = k + 1) begin
      c = drv_en[k] ? {drv_val[k], 1'b0} : level[2*k+:2];
      above_high[k] = c == 2'h2;
      below_low[k] = c == 2'h0;
      above_commutate[k] = c == 2'h2;
    end
  end
endmodule

`default_nettype wire

// ---- test/pin_ctrl_chk.sv ----
// Checker of the compare and pin control outputs of the controller.
// Assumes it is bound to the controller's top module.
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_consts.vh"

module pin_ctrl_chk #(
  parameter PINS = 8
) (
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic [4*PINS-1:0] vec_state,
  input wire logic              vec_strobe,
  input wire logic              vec_match,
  input wire logic [PINS-1:0]   drv_en,
  input wire logic [PINS-1:0]   cmp_en,
  input wire logic [PINS-1:0]   load_en,
  input wire logic [PINS-1:0]   term_en,
  input wire logic [PINS-1:0]   pmu_connect,
  input wire logic              cycle_fail,
  input wire logic              cycle_valid,
  input wire logic [PINS-1:0]   pin_mismatch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_VALID_AFTER_STROBE:
    assert property (vec_strobe |=> cycle_valid) else $error("no result after strobe");
  AST_RESULTS_HOLD:
    assert property (!vec_strobe |=> !cycle_valid && $stable(pin_mismatch))
      else $error("result changed without strobe");
  AST_MATCH_SUPPRESS:
    assert property (vec_strobe && vec_match |=> !cycle_fail) else $error("fail under match");
  AST_FAIL_ANY_PIN:
    assert property (vec_strobe && !vec_match |=> cycle_fail == (|pin_mismatch))
      else $error("fail flag disagrees with pins");
  AST_FAIL_CAUSE:
    assert property (cycle_fail |-> $past(vec_strobe) && !$past(vec_match))
      else $error("fail without unmatched strobe");
  AST_DONT_CARE:
    assert property (vec_strobe && vec_state == {PINS{`ST_DONT_CARE}} |=> pin_mismatch == 0)
      else $error("mismatch from dont care");
  AST_PMU_OFF:
    assert property ((pmu_connect & (drv_en | cmp_en | load_en)) == 0)
      else $error("pin electronics on with parametric unit");
  AST_ONE_TERMINATION:
    assert property ((load_en & term_en) == 0 && (drv_en & (load_en | term_en)) == 0)
      else $error("driver and terminations overlap");
  AST_RESET_HIZ:
    assert property ($rose(resetn) |-> drv_en == 0 && load_en == 0 && term_en == 0)
      else $error("pin not high impedance after reset");
endmodule

bind pin_compare_termination_ctrl pin_ctrl_chk #(.PINS(PINS)) chk_i (.*);

`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench of the per-pin compare and termination controller.
// Assumes the pin model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "pin_ctrl_consts.vh"

module tb;
  localparam P = 8;
  reg  [3:0]     reg_addr = 0;
  reg  [31:0]    reg_wdata = 0;
  reg            sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, vec_strobe = 0, vec_match = 0;
  reg  [4*P-1:0] vec_state = 0, st;
  reg  [2*P-1:0] lvl = 0, lv;
  reg  [31:0]    seed = 32'hB2A4, ctrl;
  wire [31:0]    reg_rdata;
  wire [P-1:0]   ah, bl, ac, drv_en, drv_val, load_en, load_source, term_en, cmp_en;
  wire [P-1:0]   pmu_connect, pin_mismatch;
  wire [2:0]     pmu_mode;
  wire           cycle_fail, cycle_valid, irq;
  integer        errors = 0, num_checks = 0, cyc = 0, exp_fails = 0, i, j, t, f;

  always #12.5 sys_clk = ~sys_clk;

  pin_compare_termination_ctrl #(.PINS(P)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec_state(vec_state), .vec_strobe(vec_strobe),
    .vec_match(vec_match), .cmp_above_high(ah), .cmp_below_low(bl), .cmp_above_commutate(ac),
    .drv_en(drv_en), .drv_val(drv_val), .load_en(load_en), .load_source(load_source),
    .term_en(term_en), .cmp_en(cmp_en), .pmu_connect(pmu_connect), .pmu_mode(pmu_mode),
    .cycle_fail(cycle_fail), .cycle_valid(cycle_valid), .pin_mismatch(pin_mismatch), .irq(irq));

  dut_pins #(.PINS(P)) pins (.drv_en(drv_en), .drv_val(drv_val), .level(lvl),
    .above_high(ah), .below_low(bl), .above_commutate(ac));

  // ****************************************
  // Expectation functions and tasks
  // ****************************************
  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction

  // Per pin: bit 0 non-drive, bit 1 mismatch, bit 2 load sources current.
  function [2:0] pin_exp(input [3:0] s, input [1:0] c);
    begin
      pin_exp[0] = (s >= `ST_CMP_LOW && s <= `ST_DONT_CARE) || s == `ST_EDGE ||
                   (s == `ST_NO_CHANGE && ctrl[`CTRL_NOCHG_BIT]);
      pin_exp[1] = (s == `ST_CMP_LOW && c != 0) || (s == `ST_CMP_HIGH && c != 2) ||
                   (s == `ST_MIDBAND && c != 1) || (s == `ST_VALID && c == 1);
      pin_exp[2] = c != 2;
    end
  endfunction

  task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("ERROR %s expected %h seen %h", n, exp, seen);
      end
    end
  endtask

  task end_of_test;
    begin
      if (errors == 0 && num_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge sys_clk);
      reg_wr <= 0;
    end
  endtask

  task rd(input [3:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1 chk("reg_rdata", reg_rdata, e);
    end
  endtask

  // Applies one vector with device levels, checks the pin controls, then strobes it.
  task vec(input [4*P-1:0] s, input [2*P-1:0] l, input m);
    reg [P-1:0] nd, ex, src, dv, hv;
    reg         dig;
    integer     k;
    begin
      for (k = 0; k < P; k = k + 1) begin
        {src[k], ex[k], nd[k]} = pin_exp(s[4*k+:4], l[2*k+:2]);
        dv[k] = s[4*k+:4] <= `ST_DRIVE1;
        hv[k] = s[4*k+:4] == `ST_DRIVE1;
      end
      dig = ctrl[1:0] == `FUNC_DIGITAL;
      if (!dig)
        ex = 0;
      @(posedge sys_clk);
      vec_state <= s;
      lvl <= l;
      repeat (5) @(posedge sys_clk);
      #1;
      chk("load_en", load_en, (dig && ctrl[3:2] == `TERM_LOAD) ? nd : 0);
      chk("load_source", load_source & load_en, load_en & src);
      chk("term_en", term_en, (dig && ctrl[3:2] == `TERM_RESIST) ? nd : 0);
      chk("drv_en", drv_en & nd, 0);
      chk("drv_en_drive", drv_en, dig ? dv : 0);
      chk("drv_val", drv_val & drv_en, dig ? hv : 0);
      chk("cmp_en", cmp_en, dig ? {P{1'b1}} : 0);
      if (ctrl[1:0] == `FUNC_PARAMETRIC)
        chk("pmu_pins", {pmu_connect, drv_en | cmp_en | load_en}, {{P{1'b1}}, {P{1'b0}}});
      @(posedge sys_clk);
      vec_strobe <= 1;
      vec_match <= m;
      @(posedge sys_clk);
      vec_strobe <= 0;
      vec_match <= 0;
      #1;
      chk("pin_mismatch", pin_mismatch, ex);
      chk("cycle_fail", cycle_fail, (|ex) & !m);
      if (|ex && !m)
        exp_fails = exp_fails + 1;
    end
  endtask

  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      end_of_test;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1;
    rd(`REG_CTRL, `CTRL_RESET);
    rd(`REG_MASK, `MASK_RESET);
    rd(4'hF, 0);
    chk("drv_en", drv_en, 0);
    ctrl = 32'h24;
    wr(`REG_CTRL, ctrl);
    vec({P{`ST_CMP_LOW}}, {P{2'h2}}, 1);
    vec({P{`ST_DONT_CARE}}, {P{2'h1}}, 0);
    for (f = 0; f < 4; f = f + 1)
      for (t = 0; t < 3; t = t + 1) begin
        ctrl = 32'h20 | ((rnd() % 2) << `CTRL_NOCHG_BIT) | (t << 2) | f;
        wr(`REG_CTRL, ctrl);
        for (i = 0; i < 10; i = i + 1) begin
          for (j = 0; j < P; j = j + 1) begin
            st[4*j+:4] = rnd() % 9;
            lv[2*j+:2] = rnd() % 3;
          end
          vec(st, lv, rnd() % 2);
        end
      end
    ctrl = 32'h20;
    wr(`REG_CTRL, ctrl);
    wr(`REG_STATUS, 32'h3);
    wr(`REG_MASK, 32'h1);
    vec({P{`ST_CMP_HIGH}}, {P{2'h0}}, 0);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", irq, 1);
    rd(`REG_STATUS, 32'h1);
    wr(`REG_STATUS, 32'h1);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", irq, 0);
    wr(`REG_MASK, 32'h0);
    vec({P{`ST_MIDBAND}}, {P{2'h0}}, 0);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", irq, 0);
    rd(`REG_MISMATCH, 32'h000000FF);
    rd(`REG_FAILCNT, exp_fails);
    for (f = 0; f < 2; f = f + 1) begin
      ctrl = 32'h20 | f;
      wr(`REG_CTRL, ctrl);
      for (i = 0; i < 8; i = i + 1) begin
        wr(`REG_PMU, i);
        repeat (2) @(posedge sys_clk);
        #1 chk("pmu_mode", pmu_mode, (f == 1 || i == 7) ? i : 0);
      end
    end
    end_of_test;
  end
endmodule

`default_nettype wire
